// [design/rtl_table_loader.sv]
`timescale 1ns/1ps
`default_nettype none
// Remote I/O table loader for the built-in channel
module rtl_table_loader (
    // Clocking
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    // Port setup
    input  wire logic        base_valid,
    input  wire logic [15:0] base_addr,
    input  wire logic        rate_hi,
    // Setup-complete relay
    input  wire logic        setup_complete_relay,
    // Data memory read port, one cycle latency
    output logic             mem_rd,
    output logic [15:0]      mem_addr,
    input  wire logic [15:0] mem_rdata,
    // Slave list
    output logic [6:0]       slave_present,
    output logic             table_loaded,
    output logic             link_run,
    output logic [2:0]       master_station,
    output logic             bit_tick,
    // Slave description lookup
    input  wire logic [2:0]  q_slave,
    input  wire logic [1:0]  q_word,
    output logic [15:0]      q_data
);
    typedef struct packed {
        rtl_pkg::rtl_state_t st_r;
        logic [15:0]         base_r;
        logic [4:0]          idx_r;
        logic                rd_r;
        logic [15:0]         addr_r;
        logic [6:0]          present_r;
        logic                loaded_r;
        logic                run_r;
        logic [15:0]         qd_r;
        logic                tick_r;
    } rtl_tl_t;
    rtl_tl_t s_r;
    rtl_tl_t s_nxt;
    logic [15:0] desc [0:27];
    logic        tick_w;
    logic [4:0]  widx;

    // Word index inside the descriptor array
    function automatic logic [4:0] word_pos(input logic [2:0] sl,
                                            input logic [1:0] w);
        word_pos = 5'({sl, 2'b00}) + 5'(w);
    endfunction

    rtl_rate_gen u_rate (
        .clk     (clk),
        .reset   (reset),
        .ce      (ce),
        .run     (s_r.run_r),
        .rate_hi (rate_hi),
        .tick    (tick_w)
    );

    // Load sequence, then wait on the relay before the link runs
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick_r = tick_w;
        s_nxt.qd_r = (q_slave < 3'h7) ? desc[word_pos(q_slave, q_word)]
                                      : 16'h0000;
        case (s_r.st_r)
            rtl_pkg::ST_IDLE: begin
                // Table base comes from port setup, else default
                s_nxt.base_r = base_valid ? base_addr
                                          : rtl_pkg::DEFAULT_BASE;
                s_nxt.idx_r = 5'h00;
                s_nxt.st_r = rtl_pkg::ST_READ;
            end
            rtl_pkg::ST_READ: begin
                s_nxt.rd_r = 1'b1;
                // Reserved header is skipped, groups follow in order
                s_nxt.addr_r = s_r.base_r + 16'(rtl_pkg::RESV_WORDS)
                             + 16'(s_r.idx_r);
                s_nxt.st_r = rtl_pkg::ST_WAIT;
            end
            rtl_pkg::ST_WAIT: begin
                s_nxt.rd_r = 1'b0;
                if (!s_r.rd_r) begin
                    if (mem_rdata != 16'h0000) begin
                        s_nxt.present_r[s_r.idx_r[4:2]] = 1'b1;
                    end
                    // Last group word closes the load
                    if (s_r.idx_r == 5'(rtl_pkg::TABLE_WORDS
                                        - rtl_pkg::RESV_WORDS - 6'h01)) begin
                        s_nxt.loaded_r = 1'b1;
                        s_nxt.st_r = rtl_pkg::ST_READY;
                    end else begin
                        s_nxt.idx_r = s_r.idx_r + 5'h01;
                        s_nxt.st_r = rtl_pkg::ST_READ;
                    end
                end
            end
            rtl_pkg::ST_READY: begin
                if (setup_complete_relay) begin
                    s_nxt.run_r = 1'b1;
                    s_nxt.st_r = rtl_pkg::ST_RUN;
                end
            end
            rtl_pkg::ST_RUN: begin
                // No refetch while running; table read only once
                s_nxt.run_r = 1'b1;
            end
            default: s_nxt.st_r = rtl_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
            s_r.st_r <= rtl_pkg::ST_IDLE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Descriptor store, captured during the load
    assign widx = s_r.idx_r;
    always_ff @(posedge clk) begin
        if (ce && s_r.st_r == rtl_pkg::ST_WAIT && !s_r.rd_r) begin
            desc[widx] <= mem_rdata;
        end
    end

    assign mem_rd         = s_r.rd_r;
    assign mem_addr       = s_r.addr_r;
    assign slave_present  = s_r.present_r;
    assign table_loaded   = s_r.loaded_r;
    assign link_run       = s_r.run_r;
    assign master_station = rtl_pkg::MASTER_STN;
    assign bit_tick       = s_r.tick_r;
    assign q_data         = s_r.qd_r;

    // Link gating: only after a full load, only on the relay, then held
    a_run_needs_load: assert property (
        @(posedge clk) disable iff (reset)
        $rose(link_run) |-> table_loaded)
        else $error("link ran before table load");
    a_run_on_relay: assert property (
        @(posedge clk) disable iff (reset)
        (ce && s_r.st_r == rtl_pkg::ST_READY && setup_complete_relay)
        |=> link_run)
        else $error("relay did not start link");
    a_run_sticky: assert property (
        @(posedge clk) disable iff (reset)
        link_run |=> link_run)
        else $error("link dropped");
    a_no_read_run: assert property (
        @(posedge clk) disable iff (reset)
        link_run |-> !mem_rd)
        else $error("table read while running");
    // Reads stay inside the slave groups, past the reserved header
    a_addr_window: assert property (
        @(posedge clk) disable iff (reset)
        mem_rd |-> (mem_addr - s_r.base_r >= 16'(rtl_pkg::RESV_WORDS) &&
                    mem_addr - s_r.base_r < 16'(rtl_pkg::TABLE_WORDS)))
        else $error("read outside table groups");
    a_present_mark: assert property (
        @(posedge clk) disable iff (reset)
        (ce && s_r.st_r == rtl_pkg::ST_WAIT && !s_r.rd_r &&
         mem_rdata != 16'h0000) |=> slave_present[$past(s_r.idx_r[4:2])])
        else $error("nonzero word missed");
    a_master_zero: assert property (
        @(posedge clk) disable iff (reset)
        master_station == 3'h0)
        else $error("master station not zero");
    a_ready_loaded: assert property (
        @(posedge clk) disable iff (reset)
        s_r.st_r == rtl_pkg::ST_READY |-> table_loaded)
        else $error("ready without full load");
    // Main scenarios: load done, link started, slaves found
    c_loaded: cover property (@(posedge clk) $rose(table_loaded));
    c_run: cover property (@(posedge clk) $rose(link_run));
    c_present: cover property (@(posedge clk)
        table_loaded && slave_present != 7'h00);
endmodule
`default_nettype wire

// [include/rtl_pkg.sv]
// Notes on behaviour
// - One master only on the link, at station address 0.
// - Table starts at the base address chosen during port setup.
// - First four table words are reserved and skipped.
// - After them, consecutive four-word groups, one per slave, in order.
// - Group words: input start, input count, output start, output count.
// - Table spans exactly 32 words: header plus seven groups.
// - Table is fetched once shortly after powerup, not continuously.
// - Any non-zero word in a group marks that slave present.
// - Link traffic starts when the setup-complete relay is set.
// - Built-in channel table is independent of the module table.
// - Only two bit rates; master and slaves run at the chosen one.
// - Default base address is a fixed location when none is chosen.
package rtl_pkg;
    localparam int          WORD_W       = 16;
    localparam int          ADDR_W       = 16;
    localparam int          NUM_SLAVES   = 7;
    localparam int          GROUP_WORDS  = 4;
    localparam logic [5:0]  TABLE_WORDS  = 6'h20;
    localparam logic [5:0]  RESV_WORDS   = 6'h04;
    localparam logic [2:0]  MASTER_STN   = 3'h0;
    // Default base, octal 37700 of word memory
    localparam logic [15:0] DEFAULT_BASE = 16'h3FC0;
    // Word positions within a group
    localparam logic [1:0]  W_IN_ADDR    = 2'h0;
    localparam logic [1:0]  W_IN_CNT     = 2'h1;
    localparam logic [1:0]  W_OUT_ADDR   = 2'h2;
    localparam logic [1:0]  W_OUT_CNT    = 2'h3;
    // Bit rates, and divider counts at 50 MHz
    localparam int          CLK_HZ       = 50000000;
    localparam int          RATE_LO      = 19200;
    localparam int          RATE_HI      = 38400;
    localparam logic [11:0] DIV_LO       = 12'(CLK_HZ / RATE_LO);
    localparam logic [11:0] DIV_HI       = 12'(CLK_HZ / RATE_HI);
    typedef enum {ST_IDLE, ST_READ, ST_WAIT, ST_READY, ST_RUN} rtl_state_t;
endpackage

// [design/rtl_rate_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// Bit tick generator for the two allowed link rates
module rtl_rate_gen (
    // Clocking
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic ce,
    // Control
    input  wire logic run,
    input  wire logic rate_hi,
    // Tick
    output logic      tick
);
    typedef struct packed {
        logic [11:0] cnt_r;
        logic        tick_r;
    } rtl_rg_t;
    rtl_rg_t s_r;
    rtl_rg_t s_nxt;
    logic [11:0] div;

    // Only two rates exist; selecting one picks the divider
    always_comb begin
        div = rate_hi ? rtl_pkg::DIV_HI : rtl_pkg::DIV_LO;
        s_nxt = s_r;
        s_nxt.tick_r = 1'b0;
        if (!run) begin
            s_nxt.cnt_r = 12'h000;
        end else if (s_r.cnt_r >= div - 12'h001) begin
            s_nxt.cnt_r = 12'h000;
            s_nxt.tick_r = 1'b1;
        end else begin
            s_nxt.cnt_r = s_r.cnt_r + 12'h001;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick_r;
endmodule
`default_nettype wire

// [dv/rtl_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Data memory holding the table, one-cycle read latency
module rtl_mem_model (
    // Clocking
    input  wire logic        clk,
    // Read port
    input  wire logic        mem_rd,
    input  wire logic [15:0] mem_addr,
    output logic [15:0]      mem_rdata
);
    logic [15:0] mem [0:65535];
    logic [15:0] rdata_q = 16'h0000;
    // Data good only after a read; toggles otherwise so stale use shows
    always @(posedge clk) begin
        if (mem_rd) begin
            rdata_q <= mem[mem_addr];
        end else begin
            rdata_q <= ~rdata_q;
        end
    end
    assign mem_rdata = rdata_q;
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, reset, ce, base_valid, rate_hi, mem_rd;
    logic        setup_complete_relay, table_loaded, link_run, bit_tick;
    logic [15:0] base_addr, mem_addr, mem_rdata, q_data, exp_base;
    logic [6:0]  slave_present;
    logic [2:0]  master_station, q_slave;
    logic [1:0]  q_word;
    int          n_fail, check_count, n_rd, i;
    rtl_table_loader DUT (.clk(clk), .reset(reset), .ce(ce),
        .base_valid(base_valid), .base_addr(base_addr), .rate_hi(rate_hi),
        .setup_complete_relay(setup_complete_relay), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .slave_present(slave_present), .table_loaded(table_loaded),
        .link_run(link_run), .master_station(master_station),
        .bit_tick(bit_tick), .q_slave(q_slave), .q_word(q_word),
        .q_data(q_data));
    rtl_mem_model PM (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string s, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Present slaves hold one non-zero word, position varies by slave
    function automatic logic [15:0] exp_w(input logic [6:0] m, input int s,
                                          input int w);
        return (s < 7 && m[s] && w == s % 4) ? 16'hA000 + 16'(s)
                                             : 16'h0000;
    endfunction
    // Reads must walk upward from base+4, one word each
    always @(posedge clk) if (!reset && mem_rd) begin
        chk("mem_addr", exp_base + 16'(n_rd + 4), mem_addr);
        n_rd++;
    end
    // Reset, load a table, then query every stored word
    task automatic load(input logic bv, input logic [15:0] ba,
                        input logic rh, input logic [6:0] m);
        @(negedge clk);
        reset = 1;
        setup_complete_relay = 0;
        base_valid = bv;
        base_addr = ba;
        rate_hi = rh;
        exp_base = bv ? ba : rtl_pkg::DEFAULT_BASE;
        for (i = 0; i < 32; i++)
            PM.mem[exp_base + 16'(i)] = (i < 4) ? 16'hFFFF
                : exp_w(m, i / 4 - 1, i % 4);
        repeat (16) @(negedge clk);
        n_rd = 0;
        reset = 0;
        for (i = 0; i < 400 && !table_loaded; i++) @(negedge clk);
        chk("loaded", 16'h0001, {15'h0000, table_loaded});
        chk("n_rd", 16'h001C, 16'(n_rd));
        chk("present", {9'h000, m}, {9'h000, slave_present});
        for (i = 0; i < 32; i++) begin
            q_slave = 3'(i / 4);
            q_word = 2'(i);
            @(negedge clk);
            chk("q_data", exp_w(m, i / 4, i % 4), q_data);
        end
        chk("master", 16'h0000, {13'h0000, master_station});
    endtask
    // Gap between ticks must equal the divider
    task automatic tick_gap(input logic [15:0] d);
        for (i = 0; i < 3000 && !bit_tick; i++) @(negedge clk);
        @(negedge clk);
        for (i = 1; i < 3000 && !bit_tick; i++) @(negedge clk);
        chk("tick_gap", d, 16'(i));
    endtask
    // Default base, sparse slaves, relay gates the link
    task automatic sc_default;
        load(0, 16'h1234, 1, 7'b1001011);
        repeat (8) @(negedge clk);
        chk("run_early", 16'h0000, {14'h0000, link_run, bit_tick});
        setup_complete_relay = 1;
        @(negedge clk);
        @(negedge clk);
        chk("link_run", 16'h0001, {15'h0000, link_run});
        tick_gap(16'(rtl_pkg::DIV_HI));
    endtask
    // Chosen base, full table, slow rate; no refetch later
    task automatic sc_chosen;
        load(1, 16'h0100, 0, 7'h7F);
        PM.mem[16'h0104] = 16'h5555;
        // Clock enable low must freeze the relay start
        ce = 1'h0;
        setup_complete_relay = 1'h1;
        repeat (4) @(negedge clk);
        chk("ce_freeze", 16'h0000, {15'h0000, link_run});
        ce = 1'h1;
        tick_gap(16'(rtl_pkg::DIV_LO));
        q_slave = 3'h0;
        q_word = 2'h0;
        @(negedge clk);
        @(negedge clk);
        chk("refetch", 16'hA000, q_data);
        chk("n_rd", 16'h001C, 16'(n_rd));
    endtask
    initial begin
        reset = 1;
        ce = 1;
        base_valid = 0;
        base_addr = 16'h0000;
        rate_hi = 0;
        setup_complete_relay = 0;
        q_slave = 3'h0;
        q_word = 2'h0;
        n_fail = 0;
        check_count = 0;
        n_rd = 0;
        sc_default;
        sc_chosen;
        give_verdict;
    end
    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict;
    end
endmodule
`default_nettype wire
